// ==== rtl/mce_avs.sv ====
// Purpose: Avalon-MM slave with one wait state
// Assumes: Master holds request until waitrequest is low
// Notes: Write commits at the edge that ends the acknowledge cycle
`timescale 1ns/1ps
module mce_avs (
	input wire logic core_clk_i, // Clock
	input wire logic rst_b_i, // Async reset, low
	input wire logic [4:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Byte lanes
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall
	mce_reg_if.bus rif // Core access
);
	mce_pkg::mce_bus_s s_q, s_d; // Slave state

	// Request always visible; commit only in the acknowledge cycle
	assign rif.idx = avs_address_i[4:2];
	assign rif.wdata = avs_writedata_i;
	assign rif.be = avs_byteenable_i;
	assign rif.wr = (s_q.st == mce_pkg::MCE_ACK) && avs_write_i;
	assign avs_readdata_o = s_q.rdata;
	assign avs_waitrequest_o = s_q.wait_n;

	// Next state
	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			mce_pkg::MCE_IDLE: begin
				// Capture read data so it stands with waitrequest low
				if (avs_read_i || avs_write_i) begin
					s_d.st = mce_pkg::MCE_ACK;
					s_d.wait_n = 1'b0;
					s_d.rdata = avs_read_i ? rif.rdata : 32'h0000_0000;
				end
			end
			mce_pkg::MCE_ACK: begin
				// Held request must not retrigger
				s_d.st = mce_pkg::MCE_IDLE;
				s_d.wait_n = 1'b1;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '{st: mce_pkg::MCE_IDLE, wait_n: 1'b1, rdata: 32'h0000_0000};
		end else begin
			s_q <= s_d;
		end
	end
endmodule // mce_avs

// ==== rtl/mce_pkg.sv ====
// Purpose: Types and shared functions of the channel enable block
// Assumes: 128 channels in eight blocks of sixteen
// Notes: Constants live in mce_regs.svh
package mce_pkg;
	typedef logic [15:0] mce_en_t; // One enable per channel of a block
	typedef logic [1:0] mce_blk_t; // Block select within a partition
	// Transmit multichannel setting
	typedef enum logic [1:0] {
		MCE_TX_ALL = 2'h0,
		MCE_TX_SEL = 2'h1,
		MCE_TX_MASK = 2'h2,
		MCE_TX_SYM = 2'h3
	} mce_txm_e;
	// Bus slave states, Gray coded
	typedef enum logic {MCE_IDLE = 1'b0, MCE_ACK = 1'b1} mce_bus_e;
	// Bus slave state
	typedef struct packed {
		mce_bus_e st;
		logic wait_n; // Waitrequest level
		logic [31:0] rdata;
	} mce_bus_s;
	// Core state
	typedef struct packed {
		mce_en_t rxa, rxb, txa, txb;
		logic rx_on;
		logic [1:0] txm;
		mce_blk_t rba, rbb, tba, tbb;
		logic [2:0] rx_cur, tx_cur;
		logic rx_cp, tx_cp, dout, oe_b;
	} mce_core_s;
	// Absolute block: partition A even, B odd
	function automatic logic [2:0] abs_blk(input logic part_b, input mce_blk_t sel);
		abs_blk = {sel, part_b};
	endfunction
	// Absolute channel: sixteen per block plus bit index
	function automatic logic [6:0] abs_chan(input logic [2:0] blk, input logic [3:0] n);
		abs_chan = {blk, n};
	endfunction
	// Byte-lane merge of a 16-bit register
	function automatic mce_en_t wmerge(input mce_en_t old, input logic [31:0] wd, input logic [3:0] be);
		wmerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction
endpackage : mce_pkg

// ==== rtl/mce_reg_if.sv ====
// Purpose: Register access path between bus slave and core
// Assumes: Single clock
// Notes: wr is a one-cycle commit strobe
`timescale 1ns/1ps
interface mce_reg_if;
	logic wr; // Commit write this cycle
	logic [2:0] idx; // Word index
	logic [31:0] wdata; // Write data
	logic [3:0] be; // Byte enables
	logic [31:0] rdata; // Read data from core
	modport bus(output wr, idx, wdata, be, input rdata);
	modport core(input wr, idx, wdata, be, output rdata);
endinterface : mce_reg_if

// ==== rtl/mce_regs.svh ====
// Purpose: Register offsets, field positions and reset values
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Definitions only
`ifndef MCE_REGS_SVH
`define MCE_REGS_SVH
`define MCE_OFS_RXA 3'h0 // Word index, byte 0x00
`define MCE_OFS_RXB 3'h1 // Byte 0x04
`define MCE_OFS_TXA 3'h2 // Byte 0x08
`define MCE_OFS_TXB 3'h3 // Byte 0x0c
`define MCE_OFS_CTL 3'h4 // Byte 0x10, multichannel_control
`define MCE_OFS_STS 3'h5 // Byte 0x14, current blocks
`define MCE_EN_RST 16'h0000 // All channels off
`define MCE_BLK_RST 2'h0 // Block select reset
`define MCE_CTL_RXON 0 // rx_multichannel_on
`define MCE_CTL_TXM 1 // tx_multichannel_setting, bits 2:1
`define MCE_CTL_RBA 4 // rx_block_select_a, bits 5:4
`define MCE_CTL_RBB 6 // rx_block_select_b, bits 7:6
`define MCE_CTL_TBA 8 // tx_block_select_a, bits 9:8
`define MCE_CTL_TBB 10 // tx_block_select_b, bits 11:10
`define MCE_STS_TX 4 // Current tx block, bits 6:4
`endif

// ==== rtl/mce_sel.sv ====
// Purpose: Channel hit decode for one pair of enables
// Assumes: Channel number 0..127
// Notes: Purely combinational
`timescale 1ns/1ps
module mce_sel (
	input wire logic [6:0] chan_i, // Current channel
	input wire mce_pkg::mce_blk_t blk_a_i, // Partition A select
	input wire mce_pkg::mce_blk_t blk_b_i, // Partition B select
	input wire mce_pkg::mce_en_t en_a_i, // Partition A enables
	input wire mce_pkg::mce_en_t en_b_i, // Partition B enables
	output logic hit_o // Channel enabled
);
	logic part_b; // Odd block means partition B
	logic [2:0] blk; // Selected block of that partition

	// Bit n of a partition enables channel 16*block+n
	always_comb begin
		part_b = chan_i[4];
		blk = mce_pkg::abs_blk(part_b, part_b ? blk_b_i : blk_a_i);
		hit_o = 1'b0;
		if (chan_i == mce_pkg::abs_chan(blk, chan_i[3:0])) begin
			hit_o = part_b ? en_b_i[chan_i[3:0]] : en_a_i[chan_i[3:0]];
		end
	end
endmodule // mce_sel

// ==== rtl/mce_top.sv ====
// Purpose: Per-channel enable masks for multichannel serial operation
// Assumes: Serial framer supplies active flags and channel numbers
// Notes: Outputs lag the channel inputs by one clock
// Behaviour
// - Up to 32 channels each direction
// - Sixteen channels per partition block
// - Block selects steer enable bits
// - Receive A bit n enables channel
// - Receive B bit n enables channel
// - Transmit A bit n enables channel
// - Transmit B holds sixteen enable bits
// - Enables read/write, reset to zero
// - Even blocks A, odd blocks B
// - Data out floats unless channel driven
// - Mode bits turn selection on
// - No write to register on current block while its direction's selection is on
`timescale 1ns/1ps
`include "mce_regs.svh"
module mce_top (
	input wire logic core_clk_i, // 100 MHz clock
	input wire logic rst_b_i, // Async reset, low
	input wire logic [4:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Byte lanes
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall
	input wire logic rx_active_i, // Receive word in progress
	input wire logic [6:0] rx_chan_i, // Receive channel number
	input wire logic tx_active_i, // Transmit word in progress
	input wire logic [6:0] tx_chan_i, // Transmit channel number
	input wire logic serial_data_i, // Transmit bit from shifter
	output logic rx_copy_en_o, // Receive word kept
	output logic tx_copy_en_o, // Transmit word loaded
	output logic serial_data_out_o, // Data pin value
	output logic serial_data_out_oe_b_o // Data pin enable, low drives
);
	mce_reg_if rif(); // Register path
	mce_pkg::mce_core_s s_q, s_d; // Core state
	logic rx_hit; // Receive channel selected
	logic tx_hit; // Transmit channel selected
	logic sym_cp; // Symmetric mode: rx selection
	logic sym_dr; // Symmetric mode: tx bits on rx blocks
	logic lk_rxa, lk_rxb, lk_txa, lk_txb; // Write locks
	logic tx_cp, tx_dr; // Copy and drive for this channel
	logic [2:0] rx_cur, tx_cur; // Block in use now

	// Bus front end
	mce_avs u_avs (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.rif(rif.bus)
	);

	// Receive selection
	mce_sel u_rx (
		.chan_i(rx_chan_i),
		.blk_a_i(s_q.rba),
		.blk_b_i(s_q.rbb),
		.en_a_i(s_q.rxa),
		.en_b_i(s_q.rxb),
		.hit_o(rx_hit)
	);

	// Transmit selection on transmit blocks
	mce_sel u_tx (
		.chan_i(tx_chan_i),
		.blk_a_i(s_q.tba),
		.blk_b_i(s_q.tbb),
		.en_a_i(s_q.txa),
		.en_b_i(s_q.txb),
		.hit_o(tx_hit)
	);

	// Symmetric mode: which words are loaded
	mce_sel u_sym_cp (
		.chan_i(tx_chan_i),
		.blk_a_i(s_q.rba),
		.blk_b_i(s_q.rbb),
		.en_a_i(s_q.rxa),
		.en_b_i(s_q.rxb),
		.hit_o(sym_cp)
	);

	// Symmetric mode: which loaded words drive the pin
	mce_sel u_sym_dr (
		.chan_i(tx_chan_i),
		.blk_a_i(s_q.rba),
		.blk_b_i(s_q.rbb),
		.en_a_i(s_q.txa),
		.en_b_i(s_q.txb),
		.hit_o(sym_dr)
	);

	// Current block follows the framer, held between words
	assign rx_cur = rx_active_i ? rx_chan_i[6:4] : s_q.rx_cur;
	assign tx_cur = tx_active_i ? tx_chan_i[6:4] : s_q.tx_cur;

	// Locks only while selection is on; off, software is free
	always_comb begin
		lk_rxa = s_q.rx_on && (mce_pkg::abs_blk(1'b0, s_q.rba) == rx_cur);
		lk_rxb = s_q.rx_on && (mce_pkg::abs_blk(1'b1, s_q.rbb) == rx_cur);
		lk_txa = (s_q.txm != 2'h0) && (mce_pkg::abs_blk(1'b0, s_q.tba) == tx_cur);
		lk_txb = (s_q.txm != 2'h0) && (mce_pkg::abs_blk(1'b1, s_q.tbb) == tx_cur);
	end

	// Copy and drive per transmit setting
	always_comb begin
		unique case (mce_pkg::mce_txm_e'(s_q.txm))
			mce_pkg::MCE_TX_ALL: begin
				// Selection off: everything sent
				tx_cp = 1'b1;
				tx_dr = 1'b1;
			end
			mce_pkg::MCE_TX_SEL: begin
				// Only selected words exist
				tx_cp = tx_hit;
				tx_dr = tx_hit;
			end
			mce_pkg::MCE_TX_MASK: begin
				// All loaded, selected ones drive
				tx_cp = 1'b1;
				tx_dr = tx_hit;
			end
			mce_pkg::MCE_TX_SYM: begin
				// Receive blocks reused, transmit bits gate the pin
				// A word that was never loaded must not reach the pin
				tx_cp = sym_cp;
				tx_dr = sym_cp && sym_dr;
			end
		endcase
	end

	// Register read mux; unmapped words read zero
	always_comb begin
		rif.rdata = 32'h0000_0000;
		unique case (rif.idx)
			`MCE_OFS_RXA: rif.rdata[15:0] = s_q.rxa;
			`MCE_OFS_RXB: rif.rdata[15:0] = s_q.rxb;
			`MCE_OFS_TXA: rif.rdata[15:0] = s_q.txa;
			`MCE_OFS_TXB: rif.rdata[15:0] = s_q.txb;
			`MCE_OFS_CTL: begin
				rif.rdata[`MCE_CTL_RXON] = s_q.rx_on;
				rif.rdata[`MCE_CTL_TXM +: 2] = s_q.txm;
				rif.rdata[`MCE_CTL_RBA +: 2] = s_q.rba;
				rif.rdata[`MCE_CTL_RBB +: 2] = s_q.rbb;
				rif.rdata[`MCE_CTL_TBA +: 2] = s_q.tba;
				rif.rdata[`MCE_CTL_TBB +: 2] = s_q.tbb;
			end
			`MCE_OFS_STS: begin
				rif.rdata[2:0] = s_q.rx_cur;
				rif.rdata[`MCE_STS_TX +: 3] = s_q.tx_cur;
			end
			default: rif.rdata = 32'h0000_0000;
		endcase
	end

	// Next state: register writes and channel outputs
	always_comb begin
		s_d = s_q;
		s_d.rx_cur = rx_cur;
		s_d.tx_cur = tx_cur;
		if (rif.wr) begin
			unique case (rif.idx)
				`MCE_OFS_RXA: if (!lk_rxa) s_d.rxa = mce_pkg::wmerge(s_q.rxa, rif.wdata, rif.be);
				`MCE_OFS_RXB: if (!lk_rxb) s_d.rxb = mce_pkg::wmerge(s_q.rxb, rif.wdata, rif.be);
				`MCE_OFS_TXA: if (!lk_txa) s_d.txa = mce_pkg::wmerge(s_q.txa, rif.wdata, rif.be);
				`MCE_OFS_TXB: if (!lk_txb) s_d.txb = mce_pkg::wmerge(s_q.txb, rif.wdata, rif.be);
				`MCE_OFS_CTL: begin
					if (rif.be[0]) begin
						s_d.rx_on = rif.wdata[`MCE_CTL_RXON];
						s_d.txm = rif.wdata[`MCE_CTL_TXM +: 2];
						// While selection is on, a select on, or moving onto, the current block is kept
						if (!lk_rxa && !(s_q.rx_on
							&& mce_pkg::abs_blk(1'b0, rif.wdata[`MCE_CTL_RBA +: 2]) == rx_cur))
							s_d.rba = rif.wdata[`MCE_CTL_RBA +: 2];
						if (!lk_rxb && !(s_q.rx_on
							&& mce_pkg::abs_blk(1'b1, rif.wdata[`MCE_CTL_RBB +: 2]) == rx_cur))
							s_d.rbb = rif.wdata[`MCE_CTL_RBB +: 2];
					end
					if (rif.be[1]) begin
						if (!lk_txa && !((s_q.txm != 2'h0)
							&& mce_pkg::abs_blk(1'b0, rif.wdata[`MCE_CTL_TBA +: 2]) == tx_cur))
							s_d.tba = rif.wdata[`MCE_CTL_TBA +: 2];
						if (!lk_txb && !((s_q.txm != 2'h0)
							&& mce_pkg::abs_blk(1'b1, rif.wdata[`MCE_CTL_TBB +: 2]) == tx_cur))
							s_d.tbb = rif.wdata[`MCE_CTL_TBB +: 2];
					end
				end
				default: s_d.rx_cur = rx_cur; // Status and holes ignore writes
			endcase
		end
		// Receive: selection only when the mode bit is set
		s_d.rx_cp = rx_active_i && (s_q.rx_on ? rx_hit : 1'b1);
		s_d.tx_cp = tx_active_i && tx_cp;
		// Pin floats between words and on undriven channels
		s_d.oe_b = !(tx_active_i && tx_dr);
		s_d.dout = tx_active_i && tx_dr && serial_data_i;
	end

	// State register; all enables cleared by reset
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '{rxa: `MCE_EN_RST, rxb: `MCE_EN_RST, txa: `MCE_EN_RST, txb: `MCE_EN_RST,
				rx_on: 1'b0, txm: 2'h0, rba: `MCE_BLK_RST, rbb: `MCE_BLK_RST,
				tba: `MCE_BLK_RST, tbb: `MCE_BLK_RST, rx_cur: 3'h0, tx_cur: 3'h0,
				rx_cp: 1'b0, tx_cp: 1'b0, dout: 1'b0, oe_b: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign rx_copy_en_o = s_q.rx_cp;
	assign tx_copy_en_o = s_q.tx_cp;
	assign serial_data_out_o = s_q.dout;
	assign serial_data_out_oe_b_o = s_q.oe_b;

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_rx_mode_off: assert property (rx_active_i && !s_q.rx_on |=> rx_copy_en_o)
		else $error("receive word dropped with selection off");
	a_pin_idle_float: assert property (!tx_active_i |=> serial_data_out_oe_b_o && !serial_data_out_o)
		else $error("data pin driven between words");
	a_rxa_write_lock: assert property (rif.wr && rif.idx == `MCE_OFS_RXA && lk_rxa |=> $stable(s_q.rxa))
		else $error("locked receive A register changed");
	a_rxb_write_take: assert property (rif.wr && rif.idx == `MCE_OFS_RXB && rif.be == 4'hf && !lk_rxb
		|=> s_q.rxb == $past(rif.wdata[15:0]))
		else $error("receive B write lost");
	a_txa_write_take: assert property (rif.wr && rif.idx == `MCE_OFS_TXA && rif.be == 4'hf && !lk_txa
		|=> s_q.txa == $past(rif.wdata[15:0]))
		else $error("transmit A write lost");
	a_ctl_mode_take: assert property (rif.wr && rif.idx == `MCE_OFS_CTL && rif.be[0]
		|=> s_q.rx_on == $past(rif.wdata[`MCE_CTL_RXON]))
		else $error("receive mode bit write lost");
	a_tx_sel_masked: assert property (s_q.txm == 2'h1 && tx_active_i && !tx_hit
		|=> serial_data_out_oe_b_o && !tx_copy_en_o)
		else $error("unselected transmit channel used");
	a_tx_all_driven: assert property (s_q.txm == 2'h0 && tx_active_i
		|=> !serial_data_out_oe_b_o && tx_copy_en_o)
		else $error("transmit word not sent with selection off");
	a_idle_no_copy: assert property (!rx_active_i && !tx_active_i |=> !rx_copy_en_o && !tx_copy_en_o)
		else $error("copy strobe without a word");

	// Channel maps: bit n of a register steers channel n of its block
	a_rx_part_a_map: assert property (s_q.rx_on && rx_active_i && !rx_chan_i[4]
		&& rx_chan_i[6:4] == {s_q.rba, 1'b0} && s_q.rxa[rx_chan_i[3:0]] |=> rx_copy_en_o)
		else $error("enabled receive A channel not kept");
	a_rx_disabled_bit: assert property (s_q.rx_on && rx_active_i && rx_chan_i[6:4] == {s_q.rba, 1'b0}
		&& !s_q.rxa[rx_chan_i[3:0]] |=> !rx_copy_en_o)
		else $error("disabled receive A channel kept");
	a_rx_part_b_map: assert property (s_q.rx_on && rx_active_i && rx_chan_i[6:4] == {s_q.rbb, 1'b1}
		&& s_q.rxb[rx_chan_i[3:0]] |=> rx_copy_en_o)
		else $error("enabled receive B channel not kept");
	a_tx_part_a_map: assert property (s_q.txm == 2'h1 && tx_active_i && tx_chan_i[6:4] == {s_q.tba, 1'b0}
		&& s_q.txa[tx_chan_i[3:0]] |=> tx_copy_en_o && !serial_data_out_oe_b_o)
		else $error("enabled transmit A channel not sent");
	a_tx_part_b_map: assert property (s_q.txm == 2'h1 && tx_active_i && tx_chan_i[6:4] == {s_q.tbb, 1'b1}
		&& s_q.txb[tx_chan_i[3:0]] |=> tx_copy_en_o && !serial_data_out_oe_b_o)
		else $error("enabled transmit B channel not sent");
	a_rx_other_block: assert property (s_q.rx_on && rx_active_i && rx_chan_i[6:4] != {s_q.rba, 1'b0}
		&& rx_chan_i[6:4] != {s_q.rbb, 1'b1} |=> !rx_copy_en_o)
		else $error("receive word kept outside selected blocks");

	// Write locks: registers steering the current block hold their value
	a_rxb_write_lock: assert property (rif.wr && rif.idx == `MCE_OFS_RXB && lk_rxb |=> $stable(s_q.rxb))
		else $error("locked receive B register changed");
	a_txa_write_lock: assert property (rif.wr && rif.idx == `MCE_OFS_TXA && lk_txa |=> $stable(s_q.txa))
		else $error("locked transmit A register changed");
	a_txb_write_lock: assert property (rif.wr && rif.idx == `MCE_OFS_TXB && lk_txb |=> $stable(s_q.txb))
		else $error("locked transmit B register changed");
	a_sel_write_lock: assert property (rif.wr && rif.idx == `MCE_OFS_CTL && lk_rxa
		|=> $stable(s_q.rba))
		else $error("receive A block select moved off the current block");

	// Transmit modes: masked and symmetric
	a_tx_mask_load: assert property (s_q.txm == 2'h2 && tx_active_i
		|=> tx_copy_en_o && (serial_data_out_oe_b_o == !$past(tx_hit)))
		else $error("masked mode load or drive wrong");
	a_sym_pin_data: assert property (s_q.txm == 2'h3 && tx_active_i && sym_cp && sym_dr
		|=> !serial_data_out_oe_b_o && serial_data_out_o == $past(serial_data_i))
		else $error("symmetric mode data not driven");
	a_sym_unloaded_float: assert property (s_q.txm == 2'h3 && tx_active_i && !sym_cp
		|=> serial_data_out_oe_b_o && !tx_copy_en_o)
		else $error("symmetric mode drove a word not loaded");

	// Main scenarios
	c_lock_hit: cover property (rif.wr && rif.idx == `MCE_OFS_RXA && lk_rxa);
	c_mask_drive: cover property (s_q.txm == 2'h2 && tx_active_i && tx_hit);
	c_rx_b_hit: cover property (s_q.rx_on && rx_active_i && rx_chan_i[4] && rx_hit);
	c_sym_drive: cover property (s_q.txm == 2'h3 && tx_active_i && sym_cp && sym_dr);
	c_tx_b_lock: cover property (rif.wr && rif.idx == `MCE_OFS_TXB && lk_txb);
endmodule // mce_top

// ==== verif/mce_far_end.sv ====
// Purpose: Far end of the serial bus, steps channel slots of a frame
// Assumes: One slot per clock, level handshake on go_i and done_o
// Notes: Channel never holds a stale value while idle; data holds whenever chan_o bits 0 and 3 differ
`timescale 1ns/1ps
module mce_far_end (
	input wire logic core_clk_i, // Clock
	input wire logic rst_b_i, // Async reset, low
	input wire logic go_i, // Start a frame
	input wire logic [6:0] stop_i, // Last channel of the frame
	output logic active_o, // Slot in progress
	output logic [6:0] chan_o, // Channel number
	output logic data_o, // Bit for the shifter
	output logic done_o // Frame finished
);
	// Frame stepper; data toggles whenever chan_o bits 0 and 3 match so a stuck pin shows up
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			active_o <= 1'b0;
			chan_o <= 7'h00;
			data_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			data_o <= ~data_o ^ chan_o[0] ^ chan_o[3];
			if (active_o) begin
				if (chan_o == stop_i) begin
					active_o <= 1'b0;
					done_o <= 1'b1;
				end
				chan_o <= chan_o + 7'h01;
			end else if (go_i && !done_o) begin
				active_o <= 1'b1;
				chan_o <= 7'h00;
			end else begin
				// Idle: number keeps moving, nothing to latch onto
				chan_o <= ~chan_o;
				if (!go_i) done_o <= 1'b0;
			end
		end
	end
endmodule // mce_far_end

// ==== verif/test_mce_top.sv ====
// Purpose: Self-checking bench of the channel enable block
// Assumes: Registers change only while the far end is idle
// Notes: Block selects avoid blocks 0 and 7 so config writes in the mode loop never lock
`timescale 1ns/1ps
module test_mce_top;
	logic core_clk_i = 1'b0; // Clock
	logic rst_b_i = 1'b0; // Reset, low
	logic [4:0] avs_address_i = 5'h00; // Bus address
	logic avs_read_i = 1'b0; // Bus read
	logic avs_write_i = 1'b0; // Bus write
	logic [31:0] avs_writedata_i = 32'h0; // Bus data
	logic [3:0] avs_byteenable_i = 4'hf; // Lanes
	logic [31:0] avs_readdata_o; // Read data
	logic avs_waitrequest_o; // Stall
	logic act, sdat, done, go = 1'b0; // Far end wires
	logic [6:0] chan, stop = 7'h7f; // Slot and frame end
	logic rx_copy_en_o, tx_copy_en_o, dout, oe_b; // Outputs
	int num_errors = 0, checks_done = 0, armed = 0; // Tallies
	bit [15:0] m_en [4]; // Model enables
	int rx_on, txm, rsa, rsb, tsa, tsb, ctl; // Model control fields and their word
	logic e_rx = 0, e_tx = 0, e_do = 0, e_oe = 1; // Expected next outputs
	logic [15:0] rnd = 16'h0014; // Random state
	logic [31:0] v; // Scratch
	int i, t, k; // Loops
	always #5 core_clk_i = ~core_clk_i;
	mce_top mce_top_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .rx_active_i(act), .rx_chan_i(chan), .tx_active_i(act),
		.tx_chan_i(chan + 7'h10), .serial_data_i(sdat), .rx_copy_en_o(rx_copy_en_o),
		.tx_copy_en_o(tx_copy_en_o), .serial_data_out_o(dout), .serial_data_out_oe_b_o(oe_b));
	mce_far_end mce_far_end_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .go_i(go), .stop_i(stop),
		.active_o(act), .chan_o(chan), .data_o(sdat), .done_o(done));
	// Next random value
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Channel hit: A owns even block 2*sa, B odd block 2*sb+1, bit n = ch mod 16
	function automatic bit hit(input int ch, input int sa, input int sb, input bit [15:0] ea, input bit [15:0] eb);
		return (ch / 16 == 2 * sa && ea[ch % 16]) || (ch / 16 == 2 * sb + 1 && eb[ch % 16]);
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One bus transfer, held until waitrequest is sampled low
	task xfer(input logic [4:0] a, input logic wr, input logic [31:0] wd, input logic [3:0] be);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= wd;
		avs_byteenable_i <= be;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 50);
		if (k >= 50) begin
			num_errors++;
			report_and_stop();
		end
		v = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	// Run the far end up to channel s
	task frame(input logic [6:0] s);
		stop <= s;
		go <= 1'b1;
		for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge core_clk_i);
		if (k >= 300) begin
			num_errors++;
			report_and_stop();
		end
		go <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask
	// Outputs lag the slot inputs by one clock
	always @(posedge core_clk_i) begin
		bit rs, ts, ld, dr;
		if (armed) begin
			check(rx_copy_en_o, e_rx);
			check(tx_copy_en_o, e_tx);
			check(oe_b, e_oe);
			check(dout, e_do);
		end
		rs = rx_on ? hit(chan, rsa, rsb, m_en[0], m_en[1]) : 1;
		ts = hit(7'(chan + 7'h10), tsa, tsb, m_en[2], m_en[3]);
		case (txm)
			0: {ld, dr} = 2'b11;
			1: {ld, dr} = {ts, ts};
			2: {ld, dr} = {1'b1, ts};
			default: begin
				// Symmetric: receive blocks pick loads, a word not loaded never drives
				ld = hit(7'(chan + 7'h10), rsa, rsb, m_en[0], m_en[1]);
				dr = ld && hit(7'(chan + 7'h10), rsa, rsb, m_en[2], m_en[3]);
			end
		endcase
		e_rx = act && rs;
		e_tx = act && ld;
		e_oe = !(act && dr);
		e_do = act && dr && sdat;
	end
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		armed = 1;
		for (i = 0; i < 6; i++) begin
			xfer(5'(i * 4), 0, 0, 4'hf);
			check(v, 0);
		end
		xfer(5'h18, 1, 32'hffff, 4'hf);
		xfer(5'h18, 0, 0, 4'hf);
		check(v, 0);
		rnd = lfsr(rnd);
		xfer(5'h00, 1, {16'h0, rnd}, 4'h1);
		m_en[0][7:0] = rnd[7:0];
		xfer(5'h00, 0, 0, 4'hf);
		check(v, {16'h0, m_en[0]});
		for (t = 0; t < 4; t++) begin
			for (i = 0; i < 4; i++) begin
				rnd = lfsr(rnd);
				xfer(5'(i * 4), 1, {16'h0, rnd}, 4'hf);
				m_en[i] = rnd;
				xfer(5'(i * 4), 0, 0, 4'hf);
				check(v, {16'h0, m_en[i]});
			end
			rnd = lfsr(rnd);
			rsa = 1 + rnd[1:0] % 3;
			rsb = rnd[3:2] % 3;
			tsa = 1 + rnd[5:4] % 3;
			tsb = rnd[7:6] % 3;
			txm = t;
			rx_on = t % 2;
			ctl = rx_on | txm << 1 | rsa << 4 | rsb << 6 | tsa << 8 | tsb << 10;
			xfer(5'h10, 1, ctl, 4'hf);
			xfer(5'h10, 0, 0, 4'hf);
			check(v, ctl);
			frame(7'h7f);
		end
		// Stop inside receive block 2*rsa: its enable is now frozen
		frame(7'(32 * rsa));
		xfer(5'h14, 0, 0, 4'hf);
		check(v, (2 * rsa + 1) << 4 | 2 * rsa);
		xfer(5'h00, 1, {16'h0, ~m_en[0]}, 4'hf);
		xfer(5'h00, 0, 0, 4'hf);
		check(v, {16'h0, m_en[0]});
		xfer(5'h04, 1, {16'h0, ~m_en[1]}, 4'hf);
		m_en[1] = ~m_en[1];
		xfer(5'h04, 0, 0, 4'hf);
		check(v, {16'h0, m_en[1]});
		// Transmit block 2*rsa+1 is current: B locks only when it selects that block
		xfer(5'h0c, 1, {16'h0, ~m_en[3]}, 4'hf);
		if (tsb != rsa) m_en[3] = ~m_en[3];
		xfer(5'h0c, 0, 0, 4'hf);
		check(v, {16'h0, m_en[3]});
		// Moving the receive A select off the current block is refused
		xfer(5'h10, 1, ctl ^ ((rsa ^ (rsa % 3 + 1)) << 4), 4'hf);
		xfer(5'h10, 0, 0, 4'hf);
		check(v, ctl);
		// Reset in mid-run clears every register again
		rst_b_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		for (i = 0; i < 6; i++) begin
			xfer(5'(i * 4), 0, 0, 4'hf);
			check(v, 0);
		end
		report_and_stop();
	end
endmodule // test_mce_top
